// file: rtl/acd_capture_map.vh
// Register map, field positions, reset values and timing counts
`ifndef ACD_CAPTURE_MAP_VH
`define ACD_CAPTURE_MAP_VH

`define ACD_REG_CTRL1      8'h00
`define ACD_REG_CTRL2      8'h04
`define ACD_REG_STATUS     8'h08
`define ACD_REG_PTR_LOW    8'h0C
`define ACD_REG_PTR_HIGH   8'h10
`define ACD_REG_PTR_PAGE   8'h14
`define ACD_REG_RES_LOW    8'h18
`define ACD_REG_RES_HIGH   8'h1C
`define ACD_REG_OFS_HIGH   8'h20
`define ACD_REG_OFS_LOW    8'h24
`define ACD_REG_GAIN_HIGH  8'h28
`define ACD_REG_GAIN_LOW   8'h2C

`define ACD_C1_POWER       7
`define ACD_C1_EXTREF      6
`define ACD_C1_DIV_HI      5
`define ACD_C1_DIV_LO      4
`define ACD_C1_ACQ_HI      3
`define ACD_C1_ACQ_LO      2
`define ACD_C1_CONT        1
`define ACD_C1_SINGLE      0
`define ACD_C2_DMA         6
`define ACD_C2_CH_HI       3
`define ACD_C2_CH_LO       0
`define ACD_ST_DONE        0
`define ACD_ST_BUSY        1
`define ACD_ST_DMA         2

`define ACD_CTRL1_RST      8'h00
`define ACD_CTRL2_RST      8'h00
`define ACD_PTR_RST        8'h00
`define ACD_COEF_MID       14'h2000
`define ACD_COEF_HI_RST    6'h20
`define ACD_COEF_LO_RST    8'h00

`define ACD_CONV_CLKS      4'hF
`define ACD_SYNC_CLKS      4'h1
`define ACD_STOP_ID        4'hF
`define ACD_CH_AGND        4'hB
`define ACD_CH_INTREF      4'hC
`define ACD_DMA_STEP       24'h000002

`endif

// file: rtl/acd_capture.v
// Converter sequencer, calibration registers and result streaming engine
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acd_capture_map.vh"

// Function
// - Converter clock is master clock divided by one of four ratios.
// - Conversion is 15 clocks plus one sync clock plus one to four acquire.
// - Continuous mode restarts a conversion at once when the previous ends.
// - Control one bit 6 selects external reference, else internal reference.
// - Internal reference is on straight out of reset.
// - Buffered reference output is active only while converter is powered.
// - Control two bit 6 enables streaming mode.
// - Streaming writes results to 16 MB external memory at full rate.
// - List ends with repeated last ID then all-ones; all-ones means stop.
// - End of a stream run sets the conversion done flag.
// - Last two list locations never receive a result.
// - While streaming to an external target is enabled, core external accesses never reach memory.
// - Per cycle: convert previous ID, write previous result, read next ID.
// - First valid result reaches memory in the third cycle.
// - Core port access is gated for external targets, kept for internal.
// - Core keeps internal extended RAM access while stream goes external, only while extended_data_ram_enable_i is set.
// - Offset and gain coefficients are 14 bits, six high plus eight low.
// - Larger offset lowers the transfer; larger gain steepens its slope.
// - Channel code 1011 selects internal ground, 1100 internal reference.
module acd_capture #(
    parameter integer ADDR_W = 24
) (
    input  wire              clk_i,
    input  wire              rst_i,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output reg  [31:0]       wb_dat_o,
    output reg               wb_ack_o,
    input  wire              timer_trig_i,
    input  wire              ext_trig_i,
    input  wire [11:0]       adc_raw_i,
    output reg  [3:0]        adc_channel_o,
    output reg               adc_sample_o,
    output reg               adc_busy_o,
    output reg               ch_agnd_o,
    output reg               ch_intref_o,
    output reg               converter_clock_o,
    output reg               ext_ref_sel_o,
    output reg               int_ref_en_o,
    output reg               buffered_reference_output_o,
    output reg               conversion_done_flag_o,
    output reg  [ADDR_W-1:0] mem_addr_o,
    output reg  [7:0]        mem_wdata_o,
    output reg               mem_we_o,
    output reg               mem_re_o,
    input  wire [7:0]        mem_rdata_i,
    input  wire              dma_internal_i,
    input  wire              extended_data_ram_enable_i,
    output reg               core_port_access_o,
    output reg               core_extended_data_ram_access_o
);

    localparam [1:0] CS_IDLE = 2'd0;
    localparam [1:0] CS_SYNC = 2'd1;
    localparam [1:0] CS_ACQ  = 2'd2;
    localparam [1:0] CS_CONV = 2'd3;

    localparam [2:0] MS_IDLE = 3'd0;
    localparam [2:0] MS_WRH  = 3'd1;
    localparam [2:0] MS_WRL  = 3'd2;
    localparam [2:0] MS_RD   = 3'd3;
    localparam [2:0] MS_WAIT = 3'd4;
    localparam [2:0] MS_CAP  = 3'd5;

    // Half period of the converter clock in master clocks
    function [3:0] acd_half;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   acd_half = 4'h4;
                2'b01:   acd_half = 4'h1;
                2'b10:   acd_half = 4'h2;
                default: acd_half = 4'h8;
            endcase
        end
    endfunction

    // Gain is unity at mid code; offset is zero at mid code
    function [11:0] acd_correct;
        input [11:0] raw;
        input [13:0] gain;
        input [13:0] ofs;
        reg   [25:0]        prod;
        reg   signed [15:0] val;
        begin
            prod = raw * gain;
            val  = $signed({3'b000, prod[25:13]}) - $signed({2'b00, ofs})
                 + $signed({2'b00, `ACD_COEF_MID});
            if (val < 16'sh0000)
                acd_correct = 12'h000;
            else if (val > 16'sh0FFF)
                acd_correct = 12'hFFF;
            else
                acd_correct = val[11:0];
        end
    endfunction

    reg  [7:0]        ctrl1_r;
    reg  [7:0]        ctrl2_r;
    reg  [7:0]        ptrl_r;
    reg  [7:0]        ptrh_r;
    reg  [7:0]        ptrp_r;
    reg  [5:0]        ofsh_r;
    reg  [7:0]        ofsl_r;
    reg  [5:0]        gainh_r;
    reg  [7:0]        gainl_r;
    reg  [11:0]       result_r;
    reg  [3:0]        res_id_r;
    reg               pend_r;
    reg               ext_s1_r;
    reg               ext_s2_r;
    reg               ext_s3_r;
    reg               ext_lvl_r;
    reg  [3:0]        div_cnt_r;
    reg  [1:0]        cs_r;
    reg  [3:0]        ccnt_r;
    reg               dma_run_r;
    reg               stop_r;
    reg  [2:0]        ms_r;
    reg  [ADDR_W-1:0] rptr_r;
    reg  [ADDR_W-1:0] wptr_r;
    reg  [3:0]        next_id_r;
    reg               next_valid_r;
    reg  [3:0]        conv_id_r;
    reg               conv_valid_r;
    reg  [3:0]        wid_r;
    reg  [11:0]       wres_r;
    reg               wvalid_r;
    reg  [31:0]       rd_nxt;

    wire              pwr      = ctrl1_r[`ACD_C1_POWER];
    wire              dma_en   = ctrl2_r[`ACD_C2_DMA];
    wire              wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire              wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
    wire [7:0]        wdat     = wb_dat_i[7:0];
    wire [13:0]       ofs_coef = {ofsh_r, ofsl_r};
    wire [13:0]       gain_coef = {gainh_r, gainl_r};
    wire [11:0]       corr     = acd_correct(adc_raw_i, gain_coef,
                                             ofs_coef);
    wire [3:0]        half     = acd_half(ctrl1_r[`ACD_C1_DIV_HI:
                                                  `ACD_C1_DIV_LO]);
    wire              half_end = (div_cnt_r >= half - 4'h1);
    wire              ctick    = pwr & half_end & ~converter_clock_o;
    wire [3:0]        acq_last = {2'b00,
                                  ctrl1_r[`ACD_C1_ACQ_HI:`ACD_C1_ACQ_LO]};
    wire              conv_end = ctick & (cs_r == CS_CONV)
                               & (ccnt_r == `ACD_CONV_CLKS - 4'h1);
    wire              single_wr = wb_wr & (wb_adr_i == `ACD_REG_CTRL1)
                                & wdat[`ACD_C1_SINGLE];
    wire              ext_rise = (ext_s2_r == ext_s3_r) & ext_s3_r & ~ext_lvl_r;
    wire              trig     = single_wr | timer_trig_i | ext_rise;
    wire              start_idle = ctick & (cs_r == CS_IDLE) & pend_r;
    wire              dma_begin = start_idle & dma_en & ~dma_run_r;
    wire              dma_go_on = dma_run_r & dma_en & ~stop_r;
    wire              restart  = conv_end & (dma_run_r ? dma_go_on
                               : (ctrl1_r[`ACD_C1_CONT] | pend_r));
    wire              go_sync  = start_idle | restart;
    wire              dma_fin  = conv_end & dma_run_r & stop_r;
    wire              done_set = (conv_end & ~dma_run_r) | dma_fin;
    wire              done_clr = wb_wr & (wb_adr_i == `ACD_REG_STATUS)
                               & wdat[`ACD_ST_DONE];
    wire [ADDR_W-1:0] ptr_base = {ptrp_r, ptrh_r, ptrl_r};
    wire [3:0]        rd_id    = mem_rdata_i[7:4];

    // Bus slave: ack one cycle after the request, unmapped reads give zero
    always @* begin
        rd_nxt = 32'h00000000;
        case (wb_adr_i)
            `ACD_REG_CTRL1:     rd_nxt[7:0] = ctrl1_r;
            `ACD_REG_CTRL2:     rd_nxt[7:0] = ctrl2_r;
            `ACD_REG_STATUS:    rd_nxt[2:0] = {dma_run_r, adc_busy_o,
                                               conversion_done_flag_o};
            `ACD_REG_PTR_LOW:   rd_nxt[7:0] = ptrl_r;
            `ACD_REG_PTR_HIGH:  rd_nxt[7:0] = ptrh_r;
            `ACD_REG_PTR_PAGE:  rd_nxt[7:0] = ptrp_r;
            `ACD_REG_RES_LOW:   rd_nxt[7:0] = result_r[7:0];
            `ACD_REG_RES_HIGH:  rd_nxt[7:0] = {res_id_r, result_r[11:8]};
            `ACD_REG_OFS_HIGH:  rd_nxt[5:0] = ofsh_r;
            `ACD_REG_OFS_LOW:   rd_nxt[7:0] = ofsl_r;
            `ACD_REG_GAIN_HIGH: rd_nxt[5:0] = gainh_r;
            `ACD_REG_GAIN_LOW:  rd_nxt[7:0] = gainl_r;
            default:            rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl1_r  <= `ACD_CTRL1_RST;
            ctrl2_r  <= `ACD_CTRL2_RST;
            ptrl_r   <= `ACD_PTR_RST;
            ptrh_r   <= `ACD_PTR_RST;
            ptrp_r   <= `ACD_PTR_RST;
            ofsh_r   <= `ACD_COEF_HI_RST;
            ofsl_r   <= `ACD_COEF_LO_RST;
            gainh_r  <= `ACD_COEF_HI_RST;
            gainl_r  <= `ACD_COEF_LO_RST;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= rd_nxt;
            if (wb_wr) begin
                case (wb_adr_i)
                    // Start bit is a strobe, never stored
                    `ACD_REG_CTRL1:     ctrl1_r  <= {wdat[7:1], 1'b0};
                    `ACD_REG_CTRL2:     ctrl2_r  <= wdat;
                    // Loaded independently; software keeps the order
                    `ACD_REG_PTR_LOW:   ptrl_r   <= wdat;
                    `ACD_REG_PTR_HIGH:  ptrh_r   <= wdat;
                    `ACD_REG_PTR_PAGE:  ptrp_r   <= wdat;
                    `ACD_REG_OFS_HIGH:  ofsh_r   <= wdat[5:0];
                    `ACD_REG_OFS_LOW:   ofsl_r   <= wdat;
                    `ACD_REG_GAIN_HIGH: gainh_r  <= wdat[5:0];
                    `ACD_REG_GAIN_LOW:  gainl_r  <= wdat;
                    default:            ;
                endcase
            end
        end
    end

    // External trigger: three stages, accepted once stages two and three agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_r  <= 1'b0;
            ext_s2_r  <= 1'b0;
            ext_s3_r  <= 1'b0;
            ext_lvl_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_trig_i;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            if (ext_s2_r == ext_s3_r)
                ext_lvl_r <= ext_s3_r;
        end
    end

    // Converter clock divider, stopped while powered down
    always @(posedge clk_i) begin
        if (rst_i || !pwr) begin
            div_cnt_r         <= 4'h0;
            converter_clock_o <= 1'b0;
        end else if (half_end) begin
            div_cnt_r         <= 4'h0;
            converter_clock_o <= ~converter_clock_o;
        end else begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    // Conversion sequencer, stepped on converter clock rising edges
    always @(posedge clk_i) begin
        if (rst_i || !pwr) begin
            cs_r   <= CS_IDLE;
            ccnt_r <= 4'h0;
            pend_r <= 1'b0;
        end else begin
            if (go_sync)
                pend_r <= 1'b0;
            if (trig)
                pend_r <= 1'b1;
            if (ctick) begin
                case (cs_r)
                    CS_IDLE: begin
                        if (pend_r) begin
                            cs_r   <= CS_SYNC;
                            ccnt_r <= 4'h0;
                        end
                    end
                    CS_SYNC: begin
                        if (ccnt_r == `ACD_SYNC_CLKS - 4'h1) begin
                            cs_r   <= CS_ACQ;
                            ccnt_r <= 4'h0;
                        end else begin
                            ccnt_r <= ccnt_r + 4'h1;
                        end
                    end
                    CS_ACQ: begin
                        if (ccnt_r == acq_last) begin
                            cs_r   <= CS_CONV;
                            ccnt_r <= 4'h0;
                        end else begin
                            ccnt_r <= ccnt_r + 4'h1;
                        end
                    end
                    CS_CONV: begin
                        ccnt_r <= 4'h0;
                        if (conv_end)
                            cs_r <= restart ? CS_SYNC : CS_IDLE;
                        else
                            ccnt_r <= ccnt_r + 4'h1;
                    end
                    default: cs_r <= CS_IDLE;
                endcase
            end
        end
    end

    // Streaming pipeline: one memory sequence per conversion
    always @(posedge clk_i) begin
        if (rst_i) begin
            dma_run_r    <= 1'b0;
            stop_r       <= 1'b0;
            ms_r         <= MS_IDLE;
            rptr_r       <= {ADDR_W{1'b0}};
            wptr_r       <= {ADDR_W{1'b0}};
            next_id_r    <= 4'h0;
            next_valid_r <= 1'b0;
            conv_id_r    <= 4'h0;
            conv_valid_r <= 1'b0;
            wid_r        <= 4'h0;
            wres_r       <= 12'h000;
            wvalid_r     <= 1'b0;
            mem_addr_o   <= {ADDR_W{1'b0}};
            mem_wdata_o  <= 8'h00;
            mem_we_o     <= 1'b0;
            mem_re_o     <= 1'b0;
        end else begin
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            if (!dma_en || !pwr) begin
                dma_run_r <= 1'b0;
                ms_r      <= MS_IDLE;
            end else if (dma_begin) begin
                dma_run_r    <= 1'b1;
                stop_r       <= 1'b0;
                rptr_r       <= ptr_base;
                wptr_r       <= ptr_base;
                next_valid_r <= 1'b0;
                conv_valid_r <= 1'b0;
                wvalid_r     <= 1'b0;
                ms_r         <= MS_RD;
            end else if (conv_end && dma_run_r) begin
                wid_r        <= conv_id_r;
                wres_r       <= corr;
                wvalid_r     <= conv_valid_r;
                conv_id_r    <= next_id_r;
                conv_valid_r <= next_valid_r;
                next_valid_r <= 1'b0;
                // Stop ends the run before the repeated ID is written
                if (stop_r) begin
                    dma_run_r <= 1'b0;
                    ms_r      <= MS_IDLE;
                end else begin
                    ms_r <= conv_valid_r ? MS_WRH : MS_RD;
                end
            end else begin
                case (ms_r)
                    MS_WRH: begin
                        mem_addr_o  <= wptr_r;
                        mem_wdata_o <= {wid_r, wres_r[11:8]};
                        mem_we_o    <= 1'b1;
                        ms_r        <= MS_WRL;
                    end
                    MS_WRL: begin
                        mem_addr_o  <= wptr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
                        mem_wdata_o <= wres_r[7:0];
                        mem_we_o    <= 1'b1;
                        wptr_r      <= wptr_r + `ACD_DMA_STEP;
                        ms_r        <= MS_RD;
                    end
                    MS_RD: begin
                        mem_addr_o <= rptr_r;
                        mem_re_o   <= 1'b1;
                        rptr_r     <= rptr_r + `ACD_DMA_STEP;
                        ms_r       <= MS_WAIT;
                    end
                    MS_WAIT: ms_r <= MS_CAP;
                    MS_CAP: begin
                        if (rd_id == `ACD_STOP_ID)
                            stop_r <= 1'b1;
                        else begin
                            next_id_r    <= rd_id;
                            next_valid_r <= 1'b1;
                        end
                        ms_r <= MS_IDLE;
                    end
                    default: ms_r <= MS_IDLE;
                endcase
            end
        end
    end

    // Result capture, done flag and registered pin outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            result_r                    <= 12'h000;
            res_id_r                    <= 4'h0;
            conversion_done_flag_o      <= 1'b0;
            adc_channel_o               <= 4'h0;
            adc_sample_o                <= 1'b0;
            adc_busy_o                  <= 1'b0;
            ch_agnd_o                   <= 1'b0;
            ch_intref_o                 <= 1'b0;
            ext_ref_sel_o               <= 1'b0;
            int_ref_en_o                <= 1'b1;
            buffered_reference_output_o <= 1'b0;
            core_port_access_o          <= 1'b1;
            core_extended_data_ram_access_o          <= 1'b1;
        end else begin
            if (conv_end) begin
                result_r <= corr;
                res_id_r <= dma_run_r ? conv_id_r : adc_channel_o;
            end
            // A new event in the clearing cycle wins
            if (done_set)
                conversion_done_flag_o <= 1'b1;
            else if (done_clr)
                conversion_done_flag_o <= 1'b0;
            adc_channel_o <= dma_run_r ? conv_id_r
                           : ctrl2_r[`ACD_C2_CH_HI:`ACD_C2_CH_LO];
            ch_agnd_o   <= (adc_channel_o == `ACD_CH_AGND);
            ch_intref_o <= (adc_channel_o == `ACD_CH_INTREF);
            adc_sample_o <= (cs_r == CS_SYNC) | (cs_r == CS_ACQ);
            adc_busy_o   <= (cs_r != CS_IDLE);
            ext_ref_sel_o <= ctrl1_r[`ACD_C1_EXTREF];
            int_ref_en_o  <= ~ctrl1_r[`ACD_C1_EXTREF];
            buffered_reference_output_o <= pwr;
            // Core keeps running; its external cycles are simply dropped
            core_port_access_o <= ~(dma_en & ~dma_internal_i);
            core_extended_data_ram_access_o <= ~dma_en
                                | (extended_data_ram_enable_i & ~dma_internal_i);
        end
    end

endmodule // acd_capture

`default_nettype wire

// file: tb/acd_sram_model.sv
// Byte-wide static RAM on the far side of the capture engine
`timescale 1ns/1ps
`default_nettype none
module acd_sram_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    input  wire logic       re_i,
    output var  logic [7:0] rdata_o
);
    logic [7:0] mem [0:255];
    initial rdata_o = 8'h00;
    // Idle bus flips so stale data is never mistaken for a read
    always @(posedge clk_i) begin
        if (we_i) mem[addr_i] <= wdata_i;
        rdata_o <= re_i ? mem[addr_i] : ~rdata_o;
    end
endmodule // acd_sram_model
`default_nettype wire

// file: tb/acd_capture_assertions.sv
// Port-level concurrent checks for the capture controller
`timescale 1ns/1ps
`default_nettype none
module acd_capture_assertions #(
    parameter integer ADDR_W = 24
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic [3:0]        adc_channel_o,
    input wire logic              adc_busy_o,
    input wire logic              ch_agnd_o,
    input wire logic              int_ref_en_o,
    input wire logic              buffered_reference_output_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              mem_we_o,
    input wire logic              mem_re_o,
    input wire logic              dma_internal_i,
    input wire logic              core_port_access_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ref_on_a: assert property ($fell(rst_i) |-> int_ref_en_o)
        else $error("internal reference off after reset");
    ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack too long");
    bref_pwr_a: assert property ($rose(adc_busy_o) |->
        buffered_reference_output_o) else $error("convert while unpowered");
    agnd_sel_a: assert property (adc_channel_o == 4'hB &&
        $past(adc_channel_o) == 4'hB |-> ch_agnd_o) else $error("agnd code");
    pair_write_a: assert property ($rose(mem_we_o) |=>
        (mem_we_o && mem_addr_o == $past(mem_addr_o) + 1'b1) ##1
        (!mem_we_o && mem_re_o)) else $error("result pair order");
    port_gate_a: assert property (mem_we_o && !dma_internal_i |->
        !core_port_access_o) else $error("core port not gated");
    port_free_a: assert property (dma_internal_i &&
        $past(dma_internal_i) |-> core_port_access_o) else $error("port gated");
endmodule // acd_capture_assertions
bind acd_capture acd_capture_assertions #(.ADDR_W(ADDR_W))
    acd_capture_assertions_inst (.*);
`default_nettype wire

// file: tb/test_acd_capture.sv
// Self-checking bench for the capture controller
`timescale 1ns/1ps
`default_nettype none
`include "acd_capture_map.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_acd_capture;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic        tt = 0, et = 0, dint = 0, ack, agnd, cclk, eref, iren;
    logic        done, busy, we_m, re_m, pacc, xacc, iref, bref, smp, xen = 1;
    logic [7:0]  adr = 0, rd, wd, mrd;
    logic [31:0] dat = 0, dout;
    logic [3:0]  ch;
    logic [23:0] ma;
    logic [23:0] tab [5] = '{24'h20FF3F, 24'h24A5A5, 24'h28C101,
                             24'h2CFFFF, 24'h305500};
    logic [7:0]  lst [8] = '{8'h30, 8'hEE, 8'h50, 8'hEE,
                             8'h50, 8'hEE, 8'hF0, 8'hEE};
    logic [7:0]  exp [8] = '{8'h31, 8'h22, 8'h51, 8'h22,
                             8'h50, 8'hEE, 8'hF0, 8'hEE};
    int          divs [4] = '{8, 2, 4, 16};
    int          err_total = 0, n_tests = 0, cyc_cnt = 0, t0;
    always #2.5 clk_i = ~clk_i;
    acd_capture acd_capture_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .timer_trig_i(tt), .ext_trig_i(et), .adc_raw_i(12'h123),
        .adc_channel_o(ch), .adc_sample_o(smp), .adc_busy_o(busy),
        .ch_agnd_o(agnd), .ch_intref_o(iref), .converter_clock_o(cclk),
        .ext_ref_sel_o(eref), .int_ref_en_o(iren),
        .buffered_reference_output_o(bref), .conversion_done_flag_o(done),
        .mem_addr_o(ma), .mem_wdata_o(wd), .mem_we_o(we_m),
        .mem_re_o(re_m), .mem_rdata_i(mrd), .dma_internal_i(dint),
        .extended_data_ram_enable_i(xen), .core_port_access_o(pacc),
        .core_extended_data_ram_access_o(xacc));
    acd_sram_model acd_sram_model_inst (.clk_i(clk_i), .addr_i(ma[7:0]),
        .wdata_i(wd), .we_i(we_m), .re_i(re_m), .rdata_o(mrd));
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dout[7:0];
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic rst2();
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
    endtask
    task automatic rise();
        do @(posedge clk_i); while (cclk !== 1'b0);
        do @(posedge clk_i); while (cclk !== 1'b1);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        rst2();
        foreach (tab[i]) begin
            wb(1, tab[i][23:16], tab[i][15:8]);
            wb(0, tab[i][23:16], 8'h00);
            `CHK("reg", tab[i][7:0], rd)
        end
        rst2();
        `CHK("int ref", 1'b1, iren)
        wb(0, `ACD_REG_OFS_HIGH, 8'h00);
        `CHK("ofs rst", 8'h20, rd)
        for (int c = 11; c < 13; c++) begin
            wb(1, `ACD_REG_CTRL2, 8'(c));
            repeat (2) @(posedge clk_i);
            `CHK("agnd", c == 11, agnd)
            `CHK("intref", c == 12, iref)
            `CHK("channel", 4'(c), ch)
        end
        wb(1, `ACD_REG_CTRL1, 8'h40);
        repeat (2) @(posedge clk_i);
        `CHK("ext ref", 1'b1, eref)
        `CHK("bref off", 1'b0, bref)
        for (int d = 0; d < 4; d++) begin
            wb(1, `ACD_REG_CTRL1, 8'(8'h80 | (d << 4)));
            rise();
            t0 = cyc_cnt;
            rise();
            `CHK("div", divs[d], cyc_cnt - t0)
        end
        `CHK("bref on", 1'b1, bref)
        wb(1, `ACD_REG_OFS_LOW, 8'h01);
        for (int a = 0; a < 4; a += 3) begin
            wb(1, `ACD_REG_CTRL1, 8'(8'h90 | (a << 2)));
            et <= 1;
            do @(posedge clk_i); while (busy !== 1'b1);
            t0 = cyc_cnt;
            `CHK("sample", 1'b1, smp)
            et <= 0;
            do @(posedge clk_i); while (busy !== 1'b0);
            `CHK("conv time", (a + 17) * 2, cyc_cnt - t0)
        end
        wb(0, `ACD_REG_RES_LOW, 8'h00);
        `CHK("res lo", 8'h22, rd)
        // Single start plus continuous: sample phase recurs every conversion
        wb(1, `ACD_REG_CTRL1, 8'h93);
        do @(posedge clk_i); while (smp !== 1'b1);
        t0 = cyc_cnt;
        do @(posedge clk_i); while (smp !== 1'b0);
        do @(posedge clk_i); while (smp !== 1'b1);
        `CHK("cont period", 34, cyc_cnt - t0)
        wb(1, `ACD_REG_CTRL1, 8'h00);
        wb(1, `ACD_REG_PTR_LOW, 8'h10);
        wb(1, `ACD_REG_PTR_HIGH, 8'h00);
        wb(1, `ACD_REG_PTR_PAGE, 8'h00);
        wb(1, `ACD_REG_STATUS, 8'h01);
        for (int i = 0; i < 8; i++)
            acd_sram_model_inst.mem[8'h10 + i] = lst[i];
        wb(1, `ACD_REG_CTRL2, 8'h40);
        wb(1, `ACD_REG_CTRL1, 8'h90);
        `CHK("port gate", 1'b0, pacc)
        `CHK("extended_data_ram", 1'b1, xacc)
        xen <= 0;
        repeat (2) @(posedge clk_i);
        `CHK("extended_data_ram off", 1'b0, xacc)
        tt <= 1;
        @(posedge clk_i);
        tt <= 0;
        do @(posedge clk_i); while (done !== 1'b1);
        for (int i = 0; i < 8; i++)
            `CHK("mem", exp[i], acd_sram_model_inst.mem[8'h10 + i])
        dint <= 1;
        repeat (3) @(posedge clk_i);
        `CHK("port free", 1'b1, pacc)
        conclude();
    end
endmodule // test_acd_capture
`default_nettype wire
